// [logic/ctrl_port_pkg.sv]
package ctrl_port_pkg;

	// ----------------------------------------
	// Pin bundle and its idle levels
	// ----------------------------------------
	typedef struct packed {
		logic clk;
		logic phase;
		logic data;
		logic i2c_mode;
		logic sel;
	} pin_bits_s;
	localparam int unsigned PIN_W = 5;
	localparam logic [4:0] PIN_IDLE = 5'h14;

	// ----------------------------------------
	// Addresses and transfer kinds
	// ----------------------------------------
	localparam logic [4:0] TW_DEV_ADDR_LOW = 5'h08;
	localparam logic [5:0] I2C_ADDR_HIGH = 6'h0D;
	localparam logic [1:0] KIND_WRITE = 2'b01;
	localparam logic [1:0] KIND_READ = 2'b11;

	// ----------------------------------------
	// Counts
	// ----------------------------------------
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [4:0] TX_BITS = 5'h18;
	localparam logic [2:0] I2C_LAST_DATA = 3'h3;
	localparam logic [2:0] I2C_DONE = 3'h4;

	// ----------------------------------------
	// Register write carrier and link state
	// ----------------------------------------
	typedef struct packed {
		logic [6:0] addr;
		logic [15:0] data;
	} reg_write_s;

	typedef enum logic [1:0] {
		I2C_IDLE = 2'b00,
		I2C_SHIFT = 2'b01,
		I2C_ACK = 2'b10,
		I2C_IGNORE = 2'b11
	} i2c_state_e;

endpackage

// [logic/pin_filter.sv]
`timescale 1ns/10ps
module pin_filter #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [W-1:0] raw,
	output logic [W-1:0] clean
);

	// A level moves only once the second and third stages agree, which also rejects single-cycle glitches.
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					s1_q <= INIT[i];
					s2_q <= INIT[i];
					s3_q <= INIT[i];
					clean[i] <= INIT[i];
				end else begin
					s1_q <= raw[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						clean[i] <= s2_q;
					end
				end
			end
		end
	endgenerate

endmodule // pin_filter

// [logic/line_events.sv]
`timescale 1ns/10ps
module line_events (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_line,
	input wire logic data_line,
	output logic rise,
	output logic fall,
	output logic start,
	output logic stop
);

	logic clk_q;
	logic data_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			clk_q <= 1'b1;
			data_q <= 1'b1;
		end else begin
			clk_q <= clk_line;
			data_q <= data_line;
		end
	end

	assign rise = clk_line & ~clk_q;
	assign fall = ~clk_line & clk_q;
	assign start = clk_line & clk_q & data_q & ~data_line;
	assign stop = clk_line & clk_q & ~data_q & data_line;

endmodule // line_events

// [logic/ctrl_port_slave.sv]
// Summary of operation
// - Prepare-read opens with device address, kind bits 0 then 1, six address bits.
// - Prepare-read register byte: first bit 1, then A6 down to A0.
// - Device address with kind bits 11 makes the device drive the data line.
// - Read returns register address first; leading bit 0 valid, 1 invalid.
// - Then sixteen data bits: upper byte 15..8, then lower byte 7..0.
// - Two-wire mode reaches the same register map as three-wire mode.
// - In two-wire mode the clock pin is SCL and data pin is SDA.
// - In two-wire mode SCL is input only; SDA driven only for acknowledge.
// - First byte after every START is the slave address byte.
// - Slave address is 001101, a select bit, then R/W as LSB.
// - The select bit of the slave address follows the address select pin.
// - Two-wire register byte: MSB zero, then the 7-bit register address.
// - Acknowledge a matching slave address with R/W equal to 0.
// - Acknowledge the register address byte; it selects the written register.
// - Two-wire data is two bytes, upper first, each acknowledged.
// - After acknowledging the last data byte, release SDA until STOP.
// - Three-wire bytes go out in documented bit order, first-in-time bit first.
// - Sample on rising clock edges, launch read data on falling edges.
// - A mismatching three-wire device address deselects the port.
`timescale 1ns/10ps
module ctrl_port_slave (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ctrl_clock_pin,
	input wire logic ctrl_phase_pin,
	input wire logic ctrl_data_pin_i,
	output logic ctrl_data_pin_o,
	output logic ctrl_data_pin_oe,
	input wire logic addr_select_pin,
	input wire logic i2c_mode_pin,
	output logic reg_wr_stb,
	output ctrl_port_pkg::reg_write_s reg_wr,
	output logic [6:0] reg_rd_addr,
	input wire logic [15:0] reg_rd_data,
	input wire logic reg_rd_valid
);

	import ctrl_port_pkg::*;

	// ----------------------------------------
	// Pin conditioning
	// ----------------------------------------
	pin_bits_s p;
	logic rise;
	logic fall;
	logic start;
	logic stop;

	pin_filter #(
		.W(PIN_W),
		.INIT(PIN_IDLE)
	) u_filter (
		.ref_clk(ref_clk),
		.srst(srst),
		.raw({ctrl_clock_pin, ctrl_phase_pin, ctrl_data_pin_i, i2c_mode_pin, addr_select_pin}),
		.clean(p)
	);

	// The clock pin doubles as SCL and the data pin as SDA.
	line_events u_events (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_line(p.clk),
		.data_line(p.data),
		.rise(rise),
		.fall(fall),
		.start(start),
		.stop(stop)
	);

	// ----------------------------------------
	// Shared byte receiver
	// ----------------------------------------
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [2:0] bit_cnt_q;
	logic phase_q;
	logic shift_en;
	logic byte_done;
	logic phase_edge;
	i2c_state_e st_q;

	// Bits are kept in arrival order, first-in-time at the top.
	assign shift_d = {shift_q[6:0], p.data};
	assign shift_en = rise & (p.i2c_mode ? (st_q == I2C_SHIFT) : 1'b1);
	assign byte_done = shift_en & (bit_cnt_q == LAST_BIT);
	assign phase_edge = ~p.i2c_mode & (p.phase != phase_q);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= p.phase;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shift_q <= 8'h00;
			bit_cnt_q <= 3'h0;
		end else if (phase_edge || start || (st_q == I2C_ACK)) begin
			bit_cnt_q <= 3'h0;
		end else if (shift_en) begin
			shift_q <= shift_d;
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
	end

	// ----------------------------------------
	// Three-wire addressing and write path
	// ----------------------------------------
	logic sel_q;
	logic rd_q;
	logic flag_q;
	logic [1:0] tw_idx_q;
	logic [6:0] wa_q;
	logic [6:0] pend_q;
	logic [7:0] upper_q;
	logic tw_addr_done;
	logic tw_data_done;
	logic tw_write;

	assign tw_addr_done = ~p.i2c_mode & ~p.phase & byte_done;
	assign tw_data_done = ~p.i2c_mode & p.phase & byte_done & sel_q & ~rd_q;
	assign tw_write = tw_data_done & (tw_idx_q == 2'h2) & ~flag_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sel_q <= 1'b0;
			rd_q <= 1'b0;
		end else if (p.i2c_mode) begin
			sel_q <= 1'b0;
		end else if (tw_addr_done) begin
			// A foreign address drops the selection until the next address byte.
			sel_q <= (shift_d[4:0] == TW_DEV_ADDR_LOW) && (shift_d[5] == p.sel) && shift_d[6];
			rd_q <= (shift_d[7:6] == KIND_READ);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tw_idx_q <= 2'h0;
			flag_q <= 1'b0;
			pend_q <= 7'h00;
		end else if (tw_addr_done) begin
			tw_idx_q <= 2'h0;
		end else if (tw_data_done) begin
			if (tw_idx_q == 2'h0) begin
				flag_q <= shift_d[7];
				if (shift_d[7]) begin
					pend_q <= shift_d[6:0];
				end
			end
			if (tw_idx_q != 2'h3) begin
				tw_idx_q <= tw_idx_q + 2'h1;
			end
		end
	end

	assign reg_rd_addr = pend_q;

	// ----------------------------------------
	// Three-wire read transmitter
	// ----------------------------------------
	logic [23:0] tx_q;
	logic [4:0] tx_cnt_q;
	logic tx_oe_q;
	logic seen_rise_q;
	logic tx_load;
	logic tx_shift;

	assign tx_load = ~p.i2c_mode & p.phase & ~phase_q & sel_q & rd_q;
	assign tx_shift = tx_oe_q & fall & seen_rise_q;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_q <= 24'h000000;
			tx_cnt_q <= 5'h00;
			tx_oe_q <= 1'b0;
			seen_rise_q <= 1'b0;
		end else if (tx_load) begin
			tx_q <= {~reg_rd_valid, pend_q, reg_rd_data};
			tx_cnt_q <= 5'h00;
			tx_oe_q <= 1'b1;
			seen_rise_q <= 1'b0;
		end else if (p.i2c_mode || !p.phase) begin
			tx_oe_q <= 1'b0;
		end else if (tx_oe_q) begin
			if (rise) begin
				seen_rise_q <= 1'b1;
			end
			if (tx_shift) begin
				tx_q <= {tx_q[22:0], 1'b0};
				tx_cnt_q <= tx_cnt_q + 5'h01;
				seen_rise_q <= 1'b0;
				if (tx_cnt_q == TX_BITS - 5'h01) begin
					tx_oe_q <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// Two-wire slave receiver
	// ----------------------------------------
	logic [2:0] i2c_idx_q;
	logic ack_q;
	logic ack_ok;
	logic i2c_write;
	logic addr_match;

	assign addr_match = (shift_d[7:2] == I2C_ADDR_HIGH) && (shift_d[1] == p.sel) && !shift_d[0];
	assign ack_ok = (i2c_idx_q == 3'h0) ? addr_match : (i2c_idx_q <= I2C_LAST_DATA);
	assign i2c_write = p.i2c_mode & byte_done & (i2c_idx_q == I2C_LAST_DATA);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q <= I2C_IDLE;
			i2c_idx_q <= 3'h0;
			ack_q <= 1'b0;
		end else if (!p.i2c_mode || stop) begin
			st_q <= I2C_IDLE;
			ack_q <= 1'b0;
		end else if (start) begin
			st_q <= I2C_SHIFT;
			i2c_idx_q <= 3'h0;
			ack_q <= 1'b0;
		end else begin
			case (st_q)
				I2C_SHIFT: begin
					if (byte_done) begin
						st_q <= ack_ok ? I2C_ACK : I2C_IGNORE;
						i2c_idx_q <= i2c_idx_q + 3'h1;
					end
				end
				I2C_ACK: begin
					if (fall) begin
						ack_q <= ~ack_q;
						if (ack_q) begin
							st_q <= (i2c_idx_q == I2C_DONE) ? I2C_IGNORE : I2C_SHIFT;
						end
					end
				end
				default: begin
					ack_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Register write port, shared by both modes
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wa_q <= 7'h00;
			upper_q <= 8'h00;
		end else if (tw_data_done || (p.i2c_mode && byte_done)) begin
			if (p.i2c_mode ? (i2c_idx_q == 3'h1) : (tw_idx_q == 2'h0)) begin
				wa_q <= shift_d[6:0];
			end
			if (p.i2c_mode ? (i2c_idx_q == 3'h2) : (tw_idx_q == 2'h1)) begin
				upper_q <= shift_d;
			end
		end
	end

	// Both modes feed one write carrier, so the register map cannot diverge.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_wr_stb <= 1'b0;
			reg_wr <= '0;
		end else begin
			reg_wr_stb <= tw_write | i2c_write;
			if (tw_write || i2c_write) begin
				reg_wr <= '{addr: wa_q, data: {upper_q, shift_d}};
			end
		end
	end

	// ----------------------------------------
	// Data pin drive
	// ----------------------------------------
	// Only the acknowledge pulls SDA; a read in two-wire mode is not served.
	assign ctrl_data_pin_o = p.i2c_mode ? 1'b0 : tx_q[23];
	assign ctrl_data_pin_oe = p.i2c_mode ? ack_q : tx_oe_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_sda_ack_only;
		@(posedge ref_clk) disable iff (srst)
		(p.i2c_mode && ctrl_data_pin_oe) |-> (st_q == I2C_ACK) && !ctrl_data_pin_o;
	endproperty
	a_sda_ack_only: assert property (p_sda_ack_only) else $error("SDA driven outside acknowledge.");

	property p_no_ack_foreign;
		@(posedge ref_clk) disable iff (srst)
		(p.i2c_mode && byte_done && st_q == I2C_SHIFT && i2c_idx_q == 3'h0 && !addr_match && !start && !stop)
		|=> (st_q == I2C_IGNORE) ##1 !ctrl_data_pin_oe;
	endproperty
	a_no_ack_foreign: assert property (p_no_ack_foreign) else $error("Foreign slave address not ignored.");

	property p_read_addr_first;
		@(posedge ref_clk) disable iff (srst)
		tx_load |=> tx_oe_q && (tx_q[23:16] == {~$past(reg_rd_valid), $past(pend_q)});
	endproperty
	a_read_addr_first: assert property (p_read_addr_first) else $error("Read does not open with address.");

	property p_read_data;
		@(posedge ref_clk) disable iff (srst)
		tx_load |=> (tx_q[15:0] == $past(reg_rd_data)) && (tx_cnt_q == 5'h00);
	endproperty
	a_read_data: assert property (p_read_data) else $error("Read data word wrong.");

	property p_launch_on_fall;
		@(posedge ref_clk) disable iff (srst)
		(!$past(tx_load) && $changed(tx_q)) |-> $past(fall) && $past(seen_rise_q);
	endproperty
	a_launch_on_fall: assert property (p_launch_on_fall) else $error("Read bit launched off a falling edge.");

	property p_deselect;
		@(posedge ref_clk) disable iff (srst)
		(!p.i2c_mode && !sel_q) |=> !reg_wr_stb && !tx_oe_q;
	endproperty
	a_deselect: assert property (p_deselect) else $error("Deselected port still active.");

	property p_phase_high;
		@(posedge ref_clk) disable iff (srst)
		(!p.i2c_mode && ctrl_data_pin_oe) |-> $past(p.phase);
	endproperty
	a_phase_high: assert property (p_phase_high) else $error("Data pin driven in address phase.");

	property p_release_after_last;
		@(posedge ref_clk) disable iff (srst)
		(st_q == I2C_ACK && ack_q && fall && i2c_idx_q == I2C_DONE && !stop && !start && p.i2c_mode)
		|=> !ctrl_data_pin_oe [*2];
	endproperty
	a_release_after_last: assert property (p_release_after_last) else $error("SDA held after last ack.");

	property p_two_byte_write;
		@(posedge ref_clk) disable iff (srst)
		i2c_write |=> reg_wr_stb && (reg_wr.data[15:8] == $past(upper_q)) && (reg_wr.addr == $past(wa_q));
	endproperty
	a_two_byte_write: assert property (p_two_byte_write) else $error("Two-byte write assembled wrongly.");

endmodule // ctrl_port_slave

// [testbench/host_master.sv]
`timescale 1ns/10ps
module host_master (
	input wire logic ref_clk,
	input wire logic dev_o,
	input wire logic dev_oe,
	output logic clk_line,
	output logic phase_line,
	output logic data_line
);
	// ----------------------------------------
	// Shared data wire
	// ----------------------------------------
	// The line has a pull-up, so a released line reads high, never the last driven value.
	logic drv_q = 1'b1;
	logic drv_en = 1'b0;
	assign data_line = (dev_oe ? dev_o : 1'b1) & (drv_en ? drv_q : 1'b1);
	initial begin
		clk_line = 1'b1;
		phase_line = 1'b0;
	end
	// ----------------------------------------
	// Line steps, launched at the rising edge
	// ----------------------------------------
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic step(input logic c, input logic p, input logic d, input logic en, input int n, output logic s);
		@(posedge ref_clk);
		s = data_line;
		clk_line <= c;
		phase_line <= p;
		drv_q <= d;
		drv_en <= en;
		hold(n - 1);
	endtask
	// Data moves only halfway through the low time, so it never races the clock fall.
	task automatic bitx(input logic p, input logic d, input logic en, output logic s);
		logic x;
		step(1'b0, p, drv_q, drv_en, 4, x);
		step(1'b0, p, d, en, 4, x);
		step(1'b1, p, d, en, 8, s);
	endtask
	task automatic xfer(input logic p, input logic [7:0] v, input logic en, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			bitx(p, v[i], en, r[i]);
		end
	endtask
	// ----------------------------------------
	// Two-wire framing
	// ----------------------------------------
	task automatic i2c_start();
		logic x;
		step(1'b1, 1'b0, 1'b1, 1'b1, 8, x);
		step(1'b1, 1'b0, 1'b0, 1'b1, 8, x);
	endtask
	task automatic i2c_byte(input logic [7:0] v, output logic ack);
		logic [7:0] r;
		logic s;
		xfer(1'b0, v, 1'b1, r);
		bitx(1'b0, 1'b1, 1'b0, s);
		ack = ~s;
	endtask
	task automatic i2c_stop();
		logic x;
		step(1'b0, 1'b0, 1'b1, 1'b0, 4, x);
		step(1'b0, 1'b0, 1'b0, 1'b1, 4, x);
		step(1'b1, 1'b0, 1'b0, 1'b1, 8, x);
		step(1'b1, 1'b0, 1'b1, 1'b1, 8, x);
		step(1'b1, 1'b0, 1'b1, 1'b0, 8, x);
	endtask
endmodule // host_master

// [testbench/ctrl_port_slave_tb.sv]
`timescale 1ns/10ps
module ctrl_port_slave_tb;
	import ctrl_port_pkg::*;
	// ----------------------------------------
	// Clock, pins and counters
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic sel = 1'b0;
	logic i2c = 1'b0;
	logic [15:0] rd_data = 16'h0000;
	logic rd_valid = 1'b0;
	logic clk_line, phase_line, data_line, dev_o, dev_oe, wr_stb;
	reg_write_s wr;
	logic [6:0] rd_addr;
	int failures = 0;
	int checked = 0;
	int strobes = 0;
	always #5 ref_clk = ~ref_clk;
	host_master host (.ref_clk(ref_clk), .dev_o(dev_o), .dev_oe(dev_oe), .clk_line(clk_line),
		.phase_line(phase_line), .data_line(data_line));
	ctrl_port_slave dut (.ref_clk(ref_clk), .srst(srst), .ctrl_clock_pin(clk_line), .ctrl_phase_pin(phase_line),
		.ctrl_data_pin_i(data_line), .ctrl_data_pin_o(dev_o), .ctrl_data_pin_oe(dev_oe),
		.addr_select_pin(sel), .i2c_mode_pin(i2c), .reg_wr_stb(wr_stb), .reg_wr(wr),
		.reg_rd_addr(rd_addr), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid));
	// ----------------------------------------
	// Register file stand-in and checking
	// ----------------------------------------
	// Address 7F is the one invalid register, so both answers of the valid flag get seen.
	function automatic logic [15:0] content(input logic [6:0] a);
		return {a, 2'b10, ~a};
	endfunction
	always @(posedge ref_clk) begin
		rd_data <= content(rd_addr);
		rd_valid <= (rd_addr != 7'h7F);
		if (wr_stb === 1'b1) begin
			strobes <= strobes + 1;
		end
	end
	task automatic close_out();
		if (failures == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		chk_word({23'h0, got}, {23'h0, exp}, what);
	endtask
	task automatic wait_strobes(input int n);
		for (int k = 0; k < 40 && strobes < n; k++) begin
			@(posedge ref_clk);
		end
		if (strobes < n) begin
			failures++;
			$display("mismatch at %0t: write strobe never came", $time);
			close_out();
		end
	endtask
	// ----------------------------------------
	// Three-wire scenarios
	// ----------------------------------------
	task automatic tw_frame(input logic [7:0] first, input logic [23:0] body, input int nb);
		logic [7:0] r;
		logic x;
		host.xfer(1'b0, first, 1'b1, r);
		host.step(1'b1, 1'b1, 1'b1, 1'b0, 8, x);
		for (int i = 0; i < nb; i++) begin
			host.xfer(1'b1, body[23 - 8 * i -: 8], 1'b1, r);
		end
		host.step(1'b1, 1'b0, 1'b1, 1'b0, 8, x);
	endtask
	task automatic tw_write(input logic s, input logic [6:0] a, input logic [15:0] d);
		int n;
		n = strobes;
		sel <= s;
		host.hold(8);
		tw_frame({2'b01, s, 5'h08}, {1'b0, a, d}, 3);
		wait_strobes(n + 1);
		chk_word({1'b0, wr}, {1'b0, a, d}, "three-wire write");
	endtask
	task automatic tw_refused();
		int n;
		n = strobes;
		tw_frame({2'b00, sel, 5'h08}, 24'h12F00F, 3);
		tw_frame({2'b10, sel, 5'h08}, 24'h12F00F, 3);
		tw_frame({2'b01, ~sel, 5'h08}, 24'h12F00F, 3);
		host.hold(10);
		chk_word(24'(strobes), 24'(n), "refused frames wrote");
	endtask
	task automatic tw_read(input logic [6:0] a);
		logic [23:0] got;
		logic x;
		int n;
		n = strobes;
		tw_frame({2'b01, sel, 5'h08}, {1'b1, a, 16'h0000}, 1);
		chk_word({17'h0, rd_addr}, {17'h0, a}, "prepare-read address");
		host.xfer(1'b0, {2'b11, sel, 5'h08}, 1'b1, got[7:0]);
		host.step(1'b1, 1'b1, 1'b1, 1'b0, 8, x);
		for (int i = 2; i >= 0; i--) begin
			host.xfer(1'b1, 8'hFF, 1'b0, got[8 * i +: 8]);
		end
		chk_word(got, {a == 7'h7F, a, content(a)}, "read bytes");
		// The port lets go of the line only at the falling edge that follows the last bit.
		host.step(1'b0, 1'b1, 1'b1, 1'b0, 8, x);
		chk_bit(dev_oe, 1'b0, "data line still driven after read");
		host.step(1'b1, 1'b1, 1'b1, 1'b0, 8, x);
		host.step(1'b1, 1'b0, 1'b1, 1'b0, 8, x);
		chk_word(24'(strobes), 24'(n), "read wrote a register");
	endtask
	// ----------------------------------------
	// Two-wire scenario
	// ----------------------------------------
	task automatic i2c_write(input logic [7:0] first, input logic [6:0] a, input logic [15:0] d, input logic ok);
		logic ack;
		logic [7:0] bytes [4];
		int n;
		n = strobes;
		bytes = '{first, {1'b0, a}, d[15:8], d[7:0]};
		host.i2c_start();
		for (int i = 0; i < 4; i++) begin
			host.i2c_byte(bytes[i], ack);
			chk_bit(ack, ok, "acknowledge");
		end
		host.i2c_stop();
		if (ok) begin
			wait_strobes(n + 1);
			chk_word({1'b0, wr}, {1'b0, a, d}, "two-wire write");
		end
		chk_word(24'(strobes), 24'(n + int'(ok)), "two-wire write count");
		chk_bit(dev_oe, 1'b0, "data line held after transfer");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		host.hold(6);
		tw_write(1'b0, 7'h12, 16'hA55A);
		tw_write(1'b1, 7'h7F, 16'h0180);
		tw_refused();
		tw_read(7'h12);
		tw_read(7'h7F);
		i2c <= 1'b1;
		sel <= 1'b0;
		host.hold(10);
		i2c_write(8'h34, 7'h12, 16'h5AA5, 1'b1);
		sel <= 1'b1;
		host.hold(10);
		i2c_write(8'h36, 7'h00, 16'hFF01, 1'b1);
		i2c_write(8'h34, 7'h05, 16'h1234, 1'b0);
		i2c_write(8'h37, 7'h05, 16'h1234, 1'b0);
		close_out();
	end
endmodule // ctrl_port_slave_tb
